// ==== design/wcp_pkg.sv ====
// Constants, opcodes and register map of the while counter predicate generator
package wcp_pkg;
  // Comparison variants
  typedef enum logic [1:0] {
    OP_UNSIGNED_LOWER = 2'b00,
    OP_UNSIGNED_LOWER_SAME = 2'b01,
    OP_SIGNED_LESS = 2'b10
  } wcp_op_t;

  localparam int unsigned SCALAR_W = 64;
  localparam int unsigned BYTE_BITS = 8;
  localparam int unsigned DEFAULT_VL_BITS = 512;
  localparam logic DEST_PREFIX = 1'b1;
  localparam logic INVERT_SENSE = 1'b0;
  localparam int unsigned ENC_W = 16;
  localparam int unsigned ENC_INV_BIT = 15;

  // Register map
  localparam int unsigned AXI_ADDR_W = 4;
  localparam logic [AXI_ADDR_W-1:0] OFS_CTRL = 4'h0;
  localparam logic [AXI_ADDR_W-1:0] OFS_STATUS = 4'h4;
  localparam int unsigned CTRL_W = 3;
  localparam int unsigned CTRL_FEAT_BIT = 0;
  localparam int unsigned CTRL_STREAM_BIT = 1;
  localparam int unsigned CTRL_DIT_BIT = 2;
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h3;
  localparam int unsigned ST_FLAG_LSB = 28;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== design/wcp_while_gen.sv ====
// While-compare counter predicate generator with AXI4-Lite control registers
//
// How it works
// - Group of two vectors when group field is 0, four when 1.
// - Elements true from lowest while compare holds; false from first failure upward.
// - Full 64-bit compare; first operand steps by one per element, any size.
// - Unsigned lower-or-same keeps elements while stepped first <= second.
// - Unsigned lower-or-same with second at all-ones gives all-true predicate.
// - Signed less keeps elements while stepped first < second, two's complement.
// - N=first active, Z=none active, C=not last active, V cleared.
// - Destination is counter predicate 8..15, a 1 prefixed to 3-bit field.
// - Size field 00..11 selects 8<<size bit elements.
// - Predicate length is vector length bits divided by 8.
// - Elements = group multiplier times vector length over element width.
// - Undefined without feature; streaming mode checked before execution.
// - With timing bit set, latency independent of operands and flags.
// - With timing bit set, exception response independent of data and flags.
// - Unsigned lower keeps elements while stepped first < second.
//
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module wcp_while_gen
  import wcp_pkg::*;
#(
  parameter int unsigned VL_BITS = DEFAULT_VL_BITS
)(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic issueValid,
  input wire logic [1:0] opSel,
  input wire logic [1:0] sizeField,
  input wire logic groupSizeField,
  input wire logic [2:0] counterPredDestField,
  input wire logic [SCALAR_W-1:0] firstScalar,
  input wire logic [SCALAR_W-1:0] secondScalar,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic predWriteEn,
  output logic [3:0] predDestReg,
  output logic [VL_BITS/BYTE_BITS-1:0] predResult,
  output logic flagN,
  output logic flagZ,
  output logic flagC,
  output logic flagV,
  output logic undefFault,
  output logic streamTrap
);
  localparam int unsigned PL_BITS = VL_BITS / BYTE_BITS;
  localparam int unsigned CNT_W = $clog2(VL_BITS / 2) + 1;

  typedef struct packed {
    logic awRdy;
    logic wRdy;
    logic bValid;
    logic [1:0] bResp;
    logic arRdy;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic [CTRL_W-1:0] ctrl;
    logic predWe;
    logic [3:0] dest;
    logic [PL_BITS-1:0] pred;
    logic fN;
    logic fZ;
    logic fC;
    logic fV;
    logic undef;
    logic trap;
    logic [CNT_W-1:0] lastCnt;
  } wcp_state_t;

  wcp_state_t q;
  wcp_state_t d;

  logic [SCALAR_W-1:0] diff;
  logic [SCALAR_W-1:0] runLen;
  logic [SCALAR_W-1:0] elems;
  logic firstPass;
  logic allTrue;
  logic [CNT_W-1:0] count;
  logic [SCALAR_W-1:0] encWord;
  logic [PL_BITS-1:0] encPred;
  logic [31:0] statusWord;

  // One adder and comparator path, no early exit: latency is fixed
  always_comb
  begin
    // Elements per group, from vector length, size and group multiplier
    elems = SCALAR_W'(PL_BITS >> sizeField) << (32'(groupSizeField) + 1);
    diff = secondScalar - firstScalar;
    allTrue = 1'b0;
    case (wcp_op_t'(opSel))
      OP_UNSIGNED_LOWER:
      begin
        firstPass = firstScalar < secondScalar;
        runLen = diff;
      end
      OP_UNSIGNED_LOWER_SAME:
      begin
        firstPass = firstScalar <= secondScalar;
        runLen = diff + SCALAR_W'(1);
        // Stepped value wraps and still passes, so never fails
        allTrue = &secondScalar;
      end
      OP_SIGNED_LESS:
      begin
        firstPass = $signed(firstScalar) < $signed(secondScalar);
        runLen = diff;
      end
      default:
      begin
        firstPass = 1'b0;
        runLen = '0;
      end
    endcase
    // Leading run of passing elements, cut at the group size
    if (allTrue)
      count = CNT_W'(elems);
    else if (!firstPass)
      count = '0;
    else if (runLen >= elems)
      count = CNT_W'(elems);
    else
      count = CNT_W'(runLen);
    // Size marker below the count field, invert sense on top
    encWord = (SCALAR_W'(count) << (32'(sizeField) + 1)) | (SCALAR_W'(1) << sizeField);
    encPred = '0;
    if (count != '0)
    begin
      encPred[ENC_INV_BIT-1:0] = encWord[ENC_INV_BIT-1:0];
      encPred[ENC_INV_BIT] = INVERT_SENSE;
    end
    statusWord = 32'(q.lastCnt);
    statusWord[ST_FLAG_LSB +: 4] = {q.fN, q.fZ, q.fC, q.fV};
  end

  always_comb
  begin
    d = q;
    d.predWe = 1'b0;
    d.undef = 1'b0;
    d.trap = 1'b0;
    if (issueValid)
    begin
      // Feature check ranks above the streaming check
      if (!q.ctrl[CTRL_FEAT_BIT])
        d.undef = 1'b1;
      else if (!q.ctrl[CTRL_STREAM_BIT])
        d.trap = 1'b1;
      else
      begin
        // Same single cycle for every operand and flag value
        d.predWe = 1'b1;
        d.dest = {DEST_PREFIX, counterPredDestField};
        d.pred = encPred;
        d.fN = count != '0;
        d.fZ = count == '0;
        d.fC = count != CNT_W'(elems);
        d.fV = 1'b0;
        d.lastCnt = count;
      end
    end
    // Write channel: address and data taken together
    if (q.awRdy)
    begin
      d.awRdy = 1'b0;
      d.wRdy = 1'b0;
      d.bValid = 1'b1;
      d.bResp = RESP_OKAY;
      if (s_axi_awaddr == OFS_CTRL)
      begin
        if (s_axi_wstrb[0])
          d.ctrl = s_axi_wdata[CTRL_W-1:0];
      end
      else if (s_axi_awaddr != OFS_STATUS)
        d.bResp = RESP_SLVERR;
    end
    else if (!q.bValid && s_axi_awvalid && s_axi_wvalid)
    begin
      d.awRdy = 1'b1;
      d.wRdy = 1'b1;
    end
    if (q.bValid && s_axi_bready)
      d.bValid = 1'b0;
    // Read channel
    if (q.arRdy)
    begin
      d.arRdy = 1'b0;
      d.rValid = 1'b1;
      d.rResp = RESP_OKAY;
      if (s_axi_araddr == OFS_CTRL)
        d.rData = 32'(q.ctrl);
      else if (s_axi_araddr == OFS_STATUS)
        d.rData = statusWord;
      else
      begin
        d.rData = '0;
        d.rResp = RESP_SLVERR;
      end
    end
    else if (!q.rValid && s_axi_arvalid)
      d.arRdy = 1'b1;
    if (q.rValid && s_axi_rready)
      d.rValid = 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.ctrl <= CTRL_RST;
    end
    else if (clkEn)
      q <= d;
  end

  // Every output straight from the state register
  assign s_axi_awready = q.awRdy;
  assign s_axi_wready = q.wRdy;
  assign s_axi_bvalid = q.bValid;
  assign s_axi_bresp = q.bResp;
  assign s_axi_arready = q.arRdy;
  assign s_axi_rvalid = q.rValid;
  assign s_axi_rdata = q.rData;
  assign s_axi_rresp = q.rResp;
  assign predWriteEn = q.predWe;
  assign predDestReg = q.dest;
  assign predResult = q.pred;
  assign flagN = q.fN;
  assign flagZ = q.fZ;
  assign flagC = q.fC;
  assign flagV = q.fV;
  assign undefFault = q.undef;
  assign streamTrap = q.trap;

  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  logic acc;
  assign acc = issueValid && clkEn && q.ctrl[CTRL_FEAT_BIT] && q.ctrl[CTRL_STREAM_BIT];

  // Timing bit only stored: every answer already takes one cycle
  chk_fixed_latency: assert property ((issueValid && clkEn) |=> (predWriteEn || undefFault || streamTrap))
    else $error("issue not answered in one cycle");
  chk_undef_nowrite: assert property ((issueValid && clkEn && !q.ctrl[CTRL_FEAT_BIT]) |=> (undefFault && !predWriteEn))
    else $error("missing feature did not fault");
  chk_dest_prefix: assert property ((acc) |=> (predDestReg == {DEST_PREFIX, $past(counterPredDestField)}))
    else $error("wrong destination register");
  chk_flags_nzv: assert property (predWriteEn |-> (flagN == !flagZ) && !flagV)
    else $error("flag relation broken");
  chk_none_empty: assert property ((predWriteEn && flagZ) |-> (predResult == '0))
    else $error("empty count but predicate nonzero");
  chk_ls_max: assert property ((acc && opSel == OP_UNSIGNED_LOWER_SAME && (&secondScalar)) |=> (!flagC && !flagZ))
    else $error("lower-same at max not all true");
  chk_lower_fail: assert property ((acc && opSel == OP_UNSIGNED_LOWER && firstScalar >= secondScalar) |=> flagZ)
    else $error("lower compare passed when not below");
  chk_signed_less: assert property ((acc && opSel == OP_SIGNED_LESS && (&firstScalar) && secondScalar == '0) |=> !flagZ)
    else $error("signed compare treated as unsigned");
  chk_ls_equal: assert property ((acc && opSel == OP_UNSIGNED_LOWER_SAME && firstScalar == secondScalar
    && !(&secondScalar)) |=> (q.lastCnt == CNT_W'(1)))
    else $error("lower-same equal operands not one element");
  chk_ls_fail: assert property ((acc && opSel == OP_UNSIGNED_LOWER_SAME && firstScalar > secondScalar) |=> flagZ)
    else $error("lower-same compare passed when above");
  chk_signed_fail: assert property ((acc && opSel == OP_SIGNED_LESS && $signed(firstScalar) >= $signed(secondScalar))
    |=> flagZ)
    else $error("signed compare passed when not less");
  chk_trap_nowrite: assert property ((issueValid && clkEn && q.ctrl[CTRL_FEAT_BIT] && !q.ctrl[CTRL_STREAM_BIT])
    |=> (streamTrap && !undefFault && !predWriteEn))
    else $error("streaming check did not trap");
  chk_flags_hold: assert property (!predWriteEn |-> $stable({flagN, flagZ, flagC, flagV, predResult, predDestReg}))
    else $error("result changed without a write");
  chk_half_marker: assert property ((acc && sizeField == 2'h1) |=> (flagZ || predResult[1:0] == 2'h2))
    else $error("halfword size marker wrong");
  chk_group_count: assert property ((acc && opSel == OP_UNSIGNED_LOWER && firstScalar == '0 && (&secondScalar)
    && sizeField == 2'h3 && !groupSizeField) |=> (q.lastCnt == CNT_W'(2 * VL_BITS / 64) && !flagC))
    else $error("group element count wrong");
  chk_full_width: assert property ((acc && opSel == OP_UNSIGNED_LOWER && firstScalar == 64'h0000_0001_0000_0000
    && secondScalar == 64'h0000_0001_0000_0001) |=> (q.lastCnt == CNT_W'(1)))
    else $error("upper operand bits ignored");

  cov_all_true: cover property (predWriteEn && !flagC);
  cov_partial: cover property (predWriteEn && flagC && !flagZ);
  cov_undef: cover property (undefFault);
  cov_trap: cover property (streamTrap);
  cov_frozen_issue: cover property (issueValid && !clkEn);
endmodule

// ==== sim/wcp_decode_model.sv ====
// Decode stage model that issues while-compare instructions
`timescale 1ns/1ps
module wcp_decode_model
  import wcp_pkg::*;
(
  input wire logic core_clk,
  output logic issueValid,
  output logic [1:0] opSel,
  output logic [1:0] sizeField,
  output logic groupSizeField,
  output logic [2:0] counterPredDestField,
  output logic [SCALAR_W-1:0] firstScalar,
  output logic [SCALAR_W-1:0] secondScalar
);
  initial
  begin
    issueValid = 1'b0;
    opSel = 2'b00;
    sizeField = 2'b00;
    groupSizeField = 1'b0;
    counterPredDestField = 3'h0;
    firstScalar = 64'h0;
    secondScalar = 64'h0;
  end

  // One instruction per call
  task automatic issue(input logic [1:0] op, input logic [1:0] sz, input logic g, input logic [2:0] d,
    input logic [63:0] a, input logic [63:0] b);
    begin
      @(posedge core_clk);
      issueValid <= 1'b1;
      opSel <= op;
      sizeField <= sz;
      groupSizeField <= g;
      counterPredDestField <= d;
      firstScalar <= a;
      secondScalar <= b;
      @(posedge core_clk);
      issueValid <= 1'b0;
      // Stale operands scrambled so a late sample shows
      firstScalar <= ~a;
      secondScalar <= ~b;
    end
  endtask
endmodule

// ==== sim/tb_wcp_while_gen.sv ====
// Self-checking bench for the while counter predicate generator
`timescale 1ns/1ps
module tb_wcp_while_gen import wcp_pkg::*;;
  localparam int VL = 128;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clkEn = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf, predDestReg;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [1:0] opSel, sizeField, s_axi_bresp, s_axi_rresp;
  logic [2:0] counterPredDestField;
  logic [63:0] firstScalar, secondScalar;
  logic [VL/8-1:0] predResult;
  logic issueValid, groupSizeField, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic predWriteEn, flagN, flagZ, flagC, flagV, undefFault, streamTrap;
  int fail_count = 0;
  int cmp_count = 0;

  always #5 core_clk = ~core_clk;

  wcp_decode_model wcp_decode_model_i (.core_clk, .issueValid, .opSel, .sizeField, .groupSizeField,
    .counterPredDestField, .firstScalar, .secondScalar);

  wcp_while_gen #(.VL_BITS(VL)) wcp_while_gen_i (.core_clk, .rst_n, .clkEn, .issueValid, .opSel, .sizeField,
    .groupSizeField, .counterPredDestField, .firstScalar, .secondScalar, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .predWriteEn, .predDestReg, .predResult, .flagN, .flagZ, .flagC, .flagV, .undefFault,
    .streamTrap);

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tmo(input logic ok);
    if (!ok)
    begin
      fail_count++;
      finish_test();
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge core_clk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    tmo(s_axi_bvalid === 1'b1);
    chk(s_axi_bresp, er);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge core_clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    s_axi_rready <= 1'b0;
    tmo(s_axi_rvalid === 1'b1);
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
  endtask

  // Flags and counter encoding expected from one instruction
  function automatic logic [63:0] model(input logic [1:0] op, input logic [1:0] sz, input logic g,
    input logic [63:0] a, input logic [63:0] b);
    int el, cnt;
    logic last, c;
    el = (2 << g) * (VL / (8 << sz));
    cnt = 0;
    last = 1'b1;
    for (int e = 0; e < el; e++)
    begin
      c = op == 2'b00 ? a < b : op == 2'b01 ? a <= b : op == 2'b10 ? $signed(a) < $signed(b) : 1'b0;
      last = last & c;
      cnt += last;
      a++;
    end
    return {cnt > 0, cnt == 0, cnt != el, 1'b0, 1'b0, cnt == 0 ? 15'h0 : 15'((cnt << (sz + 1)) | (1 << sz))};
  endfunction

  task automatic run(input logic [1:0] op, input logic [1:0] sz, input logic g, input logic [2:0] d,
    input logic [63:0] a, input logic [63:0] b, input logic [2:0] ans);
    wcp_decode_model_i.issue(op, sz, g, d, a, b);
    @(negedge core_clk);
    chk({predWriteEn, undefFault, streamTrap}, ans);
    if (ans == 3'b100)
    begin
      chk(predDestReg, {1'b1, d});
      chk({flagN, flagZ, flagC, flagV, predResult}, model(op, sz, g, a, b));
    end
    @(negedge core_clk);
    chk({predWriteEn, undefFault, streamTrap}, 3'b000);
  endtask

  initial
  begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(OFS_CTRL, {29'h0, CTRL_RST}, RESP_OKAY);
    rd(4'h8, 32'h0, RESP_SLVERR);
    $display("Register reset test done");
    for (int i = 0; i < 8; i++)
      run(2'b00, i[1:0], i[2], i[2:0], 64'h0, 64'd12, 3'b100);
    $display("Size and group test done");
    run(2'b00, 2'b00, 1'b0, 3'h3, 64'd10, 64'd15, 3'b100);
    run(2'b01, 2'b00, 1'b0, 3'h1, 64'd5, 64'd5, 3'b100);
    run(2'b01, 2'b01, 1'b1, 3'h2, 64'hffff_ffff_ffff_fff0, 64'hffff_ffff_ffff_ffff, 3'b100);
    run(2'b01, 2'b10, 1'b0, 3'h4, 64'h0000_0000_ffff_fffe, 64'h0000_0001_0000_0001, 3'b100);
    run(2'b10, 2'b00, 1'b1, 3'h5, 64'hffff_ffff_ffff_fffd, 64'd2, 3'b100);
    run(2'b10, 2'b11, 1'b0, 3'h6, 64'h0, 64'hffff_ffff_ffff_ffff, 3'b100);
    run(2'b11, 2'b00, 1'b0, 3'h7, 64'h0, 64'd12, 3'b100);
    run(2'b00, 2'b10, 1'b1, 3'h3, 64'd20, 64'd20, 3'b100);
    run(2'b00, 2'b01, 1'b0, 3'h2, 64'h0000_0001_0000_0000, 64'h0000_0001_0000_0001, 3'b100);
    run(2'b00, 2'b11, 1'b0, 3'h0, 64'h0, 64'hffff_ffff_ffff_ffff, 3'b100);
    run(2'b10, 2'b10, 1'b0, 3'h7, 64'hffff_ffff_ffff_ffff, 64'h0, 3'b100);
    $display("Compare variant test done");
    wr(OFS_CTRL, 32'h0, RESP_OKAY);
    run(2'b00, 2'b00, 1'b0, 3'h0, 64'h0, 64'd12, 3'b010);
    wr(OFS_CTRL, 32'h1, RESP_OKAY);
    run(2'b00, 2'b00, 1'b0, 3'h0, 64'h0, 64'd12, 3'b001);
    wr(OFS_CTRL, 32'h7, RESP_OKAY);
    rd(OFS_CTRL, 32'h7, RESP_OKAY);
    wr(OFS_STATUS, 32'hffff_ffff, RESP_OKAY);
    wr(4'hc, 32'h0, RESP_SLVERR);
    run(2'b01, 2'b00, 1'b1, 3'h1, 64'd100, 64'd3, 3'b100);
    run(2'b01, 2'b00, 1'b1, 3'h2, 64'h0, 64'hffff_ffff_ffff_ffff, 3'b100);
    rd(OFS_STATUS, 32'h8000_0040, RESP_OKAY);
    $display("Control and fault test done");
    @(posedge core_clk);
    clkEn <= 1'b0;
    wcp_decode_model_i.issue(2'b00, 2'b00, 1'b0, 3'h0, 64'h0, 64'd12);
    @(negedge core_clk);
    chk({predWriteEn, undefFault, streamTrap}, 3'b000);
    @(posedge core_clk);
    clkEn <= 1'b1;
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    chk({predDestReg, flagN, flagZ, flagC, flagV, predResult}, 64'h0);
    rd(OFS_CTRL, {29'h0, CTRL_RST}, RESP_OKAY);
    run(2'b00, 2'b00, 1'b0, 3'h1, 64'h0, 64'd12, 3'b100);
    $display("Clock enable and reset test done");
    finish_test();
  end
endmodule
